// ==== hdl/dtc_cycle_gen.v ====
// Machine cycle tick generator dividing the oscillator clock.
`include "dtc_consts.vh"

module dtc_cycle_gen #(
  parameter [3:0] SLOW_DIV = `DTC_SLOW_DIV,
  parameter [3:0] FAST_DIV = `DTC_FAST_DIV
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Speed select and tick
  input wire fast,
  output wire tick
);
  reg [3:0] div_reg;
  wire [3:0] last = (fast ? FAST_DIV : SLOW_DIV) - 4'h1;

  // A switch to fast mode can leave the count past the new end; wrap it.
  assign tick = (div_reg >= last);

  always @(posedge clk) begin
    if (!rst_b) begin
      div_reg <= `DTC_DIV_RST;
    end else if (tick) begin
      div_reg <= `DTC_DIV_RST;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end
endmodule

// ==== hdl/dtc_pin_sampler.v ====
// Samples one pin once per machine cycle and flags a 1-to-0 change.
`include "dtc_consts.vh"

module dtc_pin_sampler (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Sampling
  input wire tick,
  input wire pin,
  output wire level,
  output wire fall
);
  reg level_reg;

  assign level = level_reg;
  assign fall = tick & level_reg & ~pin;

  always @(posedge clk) begin
    if (!rst_b) begin
      level_reg <= `DTC_PIN_IDLE;
    end else if (tick) begin
      level_reg <= pin;
    end
  end
endmodule

// ==== hdl/dtc_timer_top.v ====
// Dual timer/counter with mode and run/flag registers on an APB slave.
//
// Implementation choices: the register offsets and register access over APB.
`include "dtc_consts.vh"

module dtc_timer_top #(
  parameter [3:0] SLOW_DIV = `DTC_SLOW_DIV,
  parameter [3:0] FAST_DIV = `DTC_FAST_DIV
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Event and interrupt pins
  input wire timer_a_event_pin,
  input wire timer_b_event_pin,
  input wire ext_irq_a_pin_b,
  input wire ext_irq_b_pin_b,
  // Acknowledge pulses from the CPU interrupt logic
  input wire timer_a_vec_ack,
  input wire timer_b_vec_ack,
  input wire ext_irq_a_vec_ack,
  input wire ext_irq_b_vec_ack,
  // Requests to the CPU interrupt logic
  output wire timer_a_irq_req,
  output wire timer_b_irq_req,
  output wire ext_irq_a_req,
  output wire ext_irq_b_req
);

  // One count step for the 13-bit, 16-bit and auto-reload widths.
  // Result is {overflow, high byte, low byte}.
  function [16:0] dtc_step;
    input [1:0] width;
    input [7:0] hi;
    input [7:0] lo;
    reg [13:0] s13;
    reg [16:0] s16;
    begin
      s13 = {1'b0, hi, lo[`DTC_PRE_MSB:0]} + 14'h0001;
      s16 = {1'b0, hi, lo} + 17'h00001;
      case (width)
        `DTC_W13: begin
          // Upper three low-byte bits are left alone by the prescaler.
          dtc_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
        end
        `DTC_W16: begin
          dtc_step = s16;
        end
        default: begin
          if (lo == `DTC_BYTE_ONES) begin
            dtc_step = {1'b1, hi, hi};
          end else begin
            dtc_step = {1'b0, hi, lo + `DTC_BYTE_ONE};
          end
        end
      endcase
    end
  endfunction

  // Offsets that answer on the bus.
  function dtc_known;
    input [7:0] addr;
    begin
      dtc_known = (addr == `DTC_OFF_MODE) ||
                  (addr == `DTC_OFF_RUNFLAGS) ||
                  (addr == `DTC_OFF_A_LOW) ||
                  (addr == `DTC_OFF_A_HIGH) ||
                  (addr == `DTC_OFF_B_LOW) ||
                  (addr == `DTC_OFF_B_HIGH) ||
                  (addr == `DTC_OFF_CONFIG);
    end
  endfunction

  reg [7:0] mode_reg;
  reg [7:0] rf_reg;
  reg [7:0] rf_next;
  reg [7:0] a_lo_reg;
  reg [7:0] a_lo_next;
  reg [7:0] a_hi_reg;
  reg [7:0] a_hi_next;
  reg [7:0] b_lo_reg;
  reg [7:0] b_lo_next;
  reg [7:0] b_hi_reg;
  reg [7:0] b_hi_next;
  reg fast_reg;
  reg [31:0] prdata_reg;
  reg [31:0] rd_val;
  reg ovf_a;
  reg ovf_ah;
  reg ovf_b;

  wire tick;
  wire ev_a_fall;
  wire ev_b_fall;
  wire xa_level;
  wire xa_fall;
  wire xb_level;
  wire xb_fall;

  // Bus decode.
  wire known = dtc_known(paddr);
  wire access = psel & penable;
  wire wr = access & pwrite & known;
  wire wr_mode = wr && (paddr == `DTC_OFF_MODE);
  wire wr_rf = wr && (paddr == `DTC_OFF_RUNFLAGS);
  wire wr_a_lo = wr && (paddr == `DTC_OFF_A_LOW);
  wire wr_a_hi = wr && (paddr == `DTC_OFF_A_HIGH);
  wire wr_b_lo = wr && (paddr == `DTC_OFF_B_LOW);
  wire wr_b_hi = wr && (paddr == `DTC_OFF_B_HIGH);
  wire wr_cfg = wr && (paddr == `DTC_OFF_CONFIG);

  // Every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = access & ~known;
  assign prdata = prdata_reg;

  assign timer_a_irq_req = rf_reg[`DTC_A_OVF];
  assign timer_b_irq_req = rf_reg[`DTC_B_OVF];
  assign ext_irq_a_req = rf_reg[`DTC_XA_FLAG];
  assign ext_irq_b_req = rf_reg[`DTC_XB_FLAG];

  dtc_cycle_gen #(
    .SLOW_DIV(SLOW_DIV),
    .FAST_DIV(FAST_DIV)
  ) u_cycle (
    .clk(clk),
    .rst_b(rst_b),
    .fast(fast_reg),
    .tick(tick)
  );

  // The event source is trusted to stay in each level a machine cycle.
  dtc_pin_sampler u_ev_a (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tick),
    .pin(timer_a_event_pin),
    .level(),
    .fall(ev_a_fall)
  );

  dtc_pin_sampler u_ev_b (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tick),
    .pin(timer_b_event_pin),
    .level(),
    .fall(ev_b_fall)
  );

  dtc_pin_sampler u_xa (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tick),
    .pin(ext_irq_a_pin_b),
    .level(xa_level),
    .fall(xa_fall)
  );

  dtc_pin_sampler u_xb (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tick),
    .pin(ext_irq_b_pin_b),
    .level(xb_level),
    .fall(xb_fall)
  );

  // Count enables.
  wire [3:0] nib_a = mode_reg[`DTC_A_NIB];
  wire [3:0] nib_b = mode_reg[`DTC_B_NIB];
  wire [1:0] wa = {nib_a[`DTC_NIB_WHI], nib_a[`DTC_NIB_WLO]};
  wire [1:0] wb = {nib_b[`DTC_NIB_WHI], nib_b[`DTC_NIB_WLO]};
  wire split = (wa == `DTC_WSPLIT);
  wire run_a = rf_reg[`DTC_A_RUN];
  wire run_b = rf_reg[`DTC_B_RUN];
  wire en_a = run_a & (~nib_a[`DTC_NIB_QUAL] | ext_irq_a_pin_b);
  wire en_b = run_b & (~nib_b[`DTC_NIB_QUAL] | ext_irq_b_pin_b) &
              ~split & (wb != `DTC_WSPLIT);
  wire inc_a = en_a & (nib_a[`DTC_NIB_SRC] ? ev_a_fall : tick);
  wire inc_b = en_b & (nib_b[`DTC_NIB_SRC] ? ev_b_fall : tick);
  // The split high byte only ever times machine cycles.
  wire inc_ah = split & run_b & tick;

  wire [16:0] step_a = dtc_step(wa, a_hi_reg, a_lo_reg);
  wire [16:0] step_b = dtc_step(wb, b_hi_reg, b_lo_reg);

  // Timer_a count, software writes win over counting.
  always @* begin
    a_lo_next = a_lo_reg;
    a_hi_next = a_hi_reg;
    ovf_a = 1'b0;
    ovf_ah = 1'b0;
    if (split) begin
      if (inc_a) begin
        a_lo_next = a_lo_reg + `DTC_BYTE_ONE;
        ovf_a = (a_lo_reg == `DTC_BYTE_ONES);
      end
      if (inc_ah) begin
        a_hi_next = a_hi_reg + `DTC_BYTE_ONE;
        ovf_ah = (a_hi_reg == `DTC_BYTE_ONES);
      end
    end else if (inc_a) begin
      ovf_a = step_a[16];
      a_hi_next = step_a[15:8];
      a_lo_next = step_a[7:0];
    end
    if (wr_a_lo) begin
      a_lo_next = pwdata[7:0];
    end
    if (wr_a_hi) begin
      a_hi_next = pwdata[7:0];
    end
  end

  // Timer_b count.
  always @* begin
    b_lo_next = b_lo_reg;
    b_hi_next = b_hi_reg;
    ovf_b = 1'b0;
    if (inc_b) begin
      ovf_b = step_b[16];
      b_hi_next = step_b[15:8];
      b_lo_next = step_b[7:0];
    end
    if (wr_b_lo) begin
      b_lo_next = pwdata[7:0];
    end
    if (wr_b_hi) begin
      b_hi_next = pwdata[7:0];
    end
  end

  // Event sources for the flags.
  wire xa_type = rf_reg[`DTC_XA_TYPE];
  wire xb_type = rf_reg[`DTC_XB_TYPE];
  wire xa_set = xa_type ? xa_fall : ~xa_level;
  wire xb_set = xb_type ? xb_fall : ~xb_level;
  wire ta_set = ovf_a;
  wire tb_set = split ? ovf_ah : ovf_b;

  // Flags: acknowledge, then software write, then hardware set wins.
  always @* begin
    rf_next = rf_reg;
    if (timer_a_vec_ack) begin
      rf_next[`DTC_A_OVF] = 1'b0;
    end
    if (timer_b_vec_ack) begin
      rf_next[`DTC_B_OVF] = 1'b0;
    end
    if (ext_irq_a_vec_ack) begin
      rf_next[`DTC_XA_FLAG] = 1'b0;
    end
    if (ext_irq_b_vec_ack) begin
      rf_next[`DTC_XB_FLAG] = 1'b0;
    end
    if (wr_rf) begin
      // Run and type bits change only here.
      rf_next = pwdata[7:0];
    end
    if (ta_set) begin
      rf_next[`DTC_A_OVF] = 1'b1;
    end
    if (tb_set) begin
      rf_next[`DTC_B_OVF] = 1'b1;
    end
    if (xa_set) begin
      rf_next[`DTC_XA_FLAG] = 1'b1;
    end
    if (xb_set) begin
      rf_next[`DTC_XB_FLAG] = 1'b1;
    end
  end

  // Read mux.
  always @* begin
    rd_val = `DTC_RD_ZERO;
    if (paddr == `DTC_OFF_MODE) begin
      rd_val[7:0] = mode_reg;
    end else if (paddr == `DTC_OFF_RUNFLAGS) begin
      rd_val[7:0] = rf_reg;
    end else if (paddr == `DTC_OFF_A_LOW) begin
      rd_val[7:0] = a_lo_reg;
    end else if (paddr == `DTC_OFF_A_HIGH) begin
      rd_val[7:0] = a_hi_reg;
    end else if (paddr == `DTC_OFF_B_LOW) begin
      rd_val[7:0] = b_lo_reg;
    end else if (paddr == `DTC_OFF_B_HIGH) begin
      rd_val[7:0] = b_hi_reg;
    end else if (paddr == `DTC_OFF_CONFIG) begin
      rd_val[`DTC_CFG_FAST] = fast_reg;
    end
  end

  // Read data is caught in the setup cycle so it comes from a flop.
  // A count that moves during the access cycle shows its older value.
  always @(posedge clk) begin
    if (!rst_b) begin
      prdata_reg <= `DTC_RD_ZERO;
    end else if (psel & ~penable) begin
      prdata_reg <= rd_val;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      mode_reg <= `DTC_MODE_RST;
      rf_reg <= `DTC_RUNFLAGS_RST;
      fast_reg <= `DTC_CONFIG_RST;
      a_lo_reg <= `DTC_COUNT_RST;
      a_hi_reg <= `DTC_COUNT_RST;
      b_lo_reg <= `DTC_COUNT_RST;
      b_hi_reg <= `DTC_COUNT_RST;
    end else begin
      if (wr_mode) begin
        mode_reg <= pwdata[7:0];
      end
      if (wr_cfg) begin
        fast_reg <= pwdata[`DTC_CFG_FAST];
      end
      rf_reg <= rf_next;
      a_lo_reg <= a_lo_next;
      a_hi_reg <= a_hi_next;
      b_lo_reg <= b_lo_next;
      b_hi_reg <= b_hi_next;
    end
  end
endmodule

// ==== shared/dtc_consts.vh ====
// Constants shared by the dual timer/counter design files.
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH

// Register byte offsets on the APB.
`define DTC_OFF_MODE 8'h00
`define DTC_OFF_RUNFLAGS 8'h04
`define DTC_OFF_A_LOW 8'h08
`define DTC_OFF_A_HIGH 8'h0c
`define DTC_OFF_B_LOW 8'h10
`define DTC_OFF_B_HIGH 8'h14
`define DTC_OFF_CONFIG 8'h18

// Reset values.
`define DTC_MODE_RST 8'h00
`define DTC_RUNFLAGS_RST 8'h00
`define DTC_COUNT_RST 8'h00
`define DTC_CONFIG_RST 1'b0
`define DTC_PIN_IDLE 1'b1
`define DTC_DIV_RST 4'h0
`define DTC_RD_ZERO 32'h0000_0000

// Bits of timer_run_and_flags.
`define DTC_B_OVF 7
`define DTC_B_RUN 6
`define DTC_A_OVF 5
`define DTC_A_RUN 4
`define DTC_XB_FLAG 3
`define DTC_XB_TYPE 2
`define DTC_XA_FLAG 1
`define DTC_XA_TYPE 0

// Fields of one timer_mode_select nibble.
`define DTC_NIB_QUAL 3
`define DTC_NIB_SRC 2
`define DTC_NIB_WHI 1
`define DTC_NIB_WLO 0
`define DTC_A_NIB 3:0
`define DTC_B_NIB 7:4

// Count width codes.
`define DTC_W13 2'b00
`define DTC_W16 2'b01
`define DTC_W8AR 2'b10
`define DTC_WSPLIT 2'b11

// Config register: machine cycle speed select.
`define DTC_CFG_FAST 0

// Oscillator periods per machine cycle.
`define DTC_SLOW_DIV 4'hc
`define DTC_FAST_DIV 4'h6

// Count arithmetic.
`define DTC_BYTE_ONES 8'hff
`define DTC_BYTE_ONE 8'h01
`define DTC_PRE_MSB 4

`endif

// ==== verif/dtc_pin_model.sv ====
// External pins and CPU interrupt acknowledge for the timer block.
module dtc_pin_model (
  // Clock
  input wire logic clk,
  // Pins
  output logic ev_pin,
  output logic xa_pin_b,
  // Interrupt handshake
  input wire logic a_req,
  input wire logic b_req,
  output logic a_ack,
  output logic b_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ev_pin = 1'b1;
    xa_pin_b = 1'b1;
    a_ack = 1'b0;
    b_ack = 1'b0;
  end
  // Each level lasts two machine cycles so that both are sampled.
  task pulse(input int n);
    repeat (n) begin
      ev_pin <= 1'b0;
      repeat (8) @(posedge clk);
      ev_pin <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask
  task set_xa(input logic v);
    xa_pin_b <= v;
  endtask
  // The CPU vectors one cycle after a request and acknowledges once.
  always @(posedge clk) begin
    a_ack <= a_req && !a_ack;
    b_ack <= b_req && !b_ack;
  end
endmodule

// ==== verif/dtc_timer_assertions.sv ====
// Concurrent checks on the ports of the dual timer/counter.
module dtc_timer_assertions #(
  parameter [3:0] SLOW_DIV = 4'hc,
  parameter [3:0] FAST_DIV = 4'h6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and interrupt handshake
  input wire logic ext_irq_a_pin_b,
  input wire logic timer_a_vec_ack,
  input wire logic timer_b_vec_ack,
  input wire logic timer_a_irq_req,
  input wire logic timer_b_irq_req,
  input wire logic ext_irq_a_req,
  input wire logic ext_irq_b_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] low_age_reg;
  // Cycles since the interrupt pin was last low; a flag rise must follow one.
  always @(posedge clk) begin
    if (!rst_b || !ext_irq_a_pin_b) low_age_reg <= 8'h00;
    else if (low_age_reg != 8'hff) low_age_reg <= low_age_reg + 8'h01;
  end
  sequence s_access;
    psel && penable;
  endsequence
  AST_PREADY_UP:
    assert property (pready) else $error("pready low");
  AST_ERR_IN_ACCESS:
    assert property (pslverr |-> s_access) else $error("pslverr idle");
  AST_ERR_UNMAPPED:
    assert property (s_access ##0 (paddr > 8'h18) |-> pslverr)
      else $error("unmapped not refused");
  AST_UPPER_ZERO:
    assert property (prdata[31:8] == 24'h000000) else $error("prdata upper");
  AST_QUIET_AFTER_RESET:
    assert property ($rose(rst_b) |-> !(timer_a_irq_req || timer_b_irq_req
      || ext_irq_a_req || ext_irq_b_req)) else $error("request after reset");
  AST_A_ACK_CLEARS:
    assert property (timer_a_vec_ack && !psel |=> !timer_a_irq_req)
      else $error("timer_a ack ignored");
  AST_B_ACK_CLEARS:
    assert property (timer_b_vec_ack && !psel |=> !timer_b_irq_req)
      else $error("timer_b ack ignored");
  AST_XA_CAUSE:
    assert property ($rose(ext_irq_a_req) && !$past(psel)
      |-> int'(low_age_reg) < 3 * SLOW_DIV) else $error("edge flag uncaused");
endmodule

bind dtc_timer_top dtc_timer_assertions #(.SLOW_DIV(SLOW_DIV),
  .FAST_DIV(FAST_DIV)) u_chk (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ext_irq_a_pin_b(ext_irq_a_pin_b),
  .timer_a_vec_ack(timer_a_vec_ack), .timer_b_vec_ack(timer_b_vec_ack),
  .timer_a_irq_req(timer_a_irq_req), .timer_b_irq_req(timer_b_irq_req),
  .ext_irq_a_req(ext_irq_a_req), .ext_irq_b_req(ext_irq_b_req));

// ==== verif/testbench.sv ====
// Self-checking testbench for the dual timer/counter.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, psel, penable, pwrite, last_err, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic a_req, b_req, xa_req, xb_req, ev_pin, xa_pin_b, a_ack, b_ack;
  logic a_seen, b_seen, x_seen;
  logic ev_b_pin, xb_pin_b, xa_ack, xb_ack;
  int err_count, tests_run, cyc;
  dtc_timer_top #(.SLOW_DIV(4'h4), .FAST_DIV(4'h2)) DUT (.clk(clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_a_event_pin(ev_pin),
    .timer_b_event_pin(ev_b_pin),
    .ext_irq_a_pin_b(xa_pin_b), .ext_irq_b_pin_b(xb_pin_b),
    .timer_a_vec_ack(a_ack), .timer_b_vec_ack(b_ack),
    .ext_irq_a_vec_ack(xa_ack), .ext_irq_b_vec_ack(xb_ack),
    .timer_a_irq_req(a_req), .timer_b_irq_req(b_req),
    .ext_irq_a_req(xa_req), .ext_irq_b_req(xb_req));
  dtc_pin_model PM (.clk(clk), .ev_pin(ev_pin), .xa_pin_b(xa_pin_b),
    .a_req(a_req), .b_req(b_req), .a_ack(a_ack), .b_ack(b_ack));
  task tally_and_finish;
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask
  // Acknowledge one external request, then look at it once it has settled.
  task irq_ack(input logic b, input logic exp, input string what);
    if (b) xb_ack <= 1'b1;
    else xa_ack <= 1'b1;
    @(posedge clk);
    xa_ack <= 1'b0;
    xb_ack <= 1'b0;
    @(negedge clk);
    check(what, {7'h00, exp}, {7'h00, b ? xb_req : xa_req});
    @(posedge clk);
  endtask
  // Each level lasts two machine cycles so that both are sampled.
  task pulse_b(input int n);
    repeat (n) begin
      ev_b_pin <= 1'b0;
      repeat (8) @(posedge clk);
      ev_b_pin <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
           output logic [7:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] junk;
    apb(1'b1, a, d, junk);
  endtask
  task rc(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    apb(1'b0, a, 8'h00, v);
    check(what, exp, v);
  endtask
  task t_regs;
    rc(8'h00, 8'h00, "mode rst");
    rc(8'h04, 8'h00, "flags rst");
    wr(8'h00, 8'ha5);
    rc(8'h00, 8'ha5, "mode rw");
    rc(8'h1c, 8'h00, "unmapped");
    check("unmapped err", 8'h01, {7'h00, last_err});
  endtask
  task t_rate;
    for (int f = 0; f < 2; f++) begin
      wr(8'h00, 8'h01);
      wr(8'h18, f[7:0]);
      wr(8'h08, 8'h00);
      wr(8'h0c, 8'h00);
      wr(8'h04, 8'h10);
      repeat (37) @(posedge clk);
      wr(8'h04, 8'h00);
      rc(8'h08, f ? 8'h14 : 8'h0a, "rate");
    end
    wr(8'h18, 8'h00);
  endtask
  task t_cnt13;
    wr(8'h00, 8'h04);
    wr(8'h0c, 8'hff);
    wr(8'h08, 8'hfe);
    a_seen = 1'b0;
    wr(8'h04, 8'h10);
    PM.pulse(2);
    wr(8'h04, 8'h00);
    rc(8'h08, 8'he0, "c13 low");
    rc(8'h0c, 8'h00, "c13 high");
    check("a ovf", 8'h01, {7'h00, a_seen});
    check("a ack", 8'h00, {7'h00, a_req});
  endtask
  task t_reload;
    wr(8'h00, 8'h06);
    wr(8'h0c, 8'h80);
    wr(8'h08, 8'hff);
    a_seen = 1'b0;
    wr(8'h04, 8'h10);
    PM.pulse(1);
    wr(8'h04, 8'h00);
    rc(8'h08, 8'h80, "reload low");
    rc(8'h0c, 8'h80, "reload high");
    check("reload ovf", 8'h01, {7'h00, a_seen});
  endtask
  task t_gate;
    wr(8'h00, 8'h0d);
    wr(8'h08, 8'h00);
    x_seen = 1'b0;
    wr(8'h04, 8'h11);
    PM.set_xa(1'b0);
    PM.pulse(2);
    rc(8'h08, 8'h00, "gated");
    check("xa edge", 8'h01, {7'h00, x_seen});
    rc(8'h04, 8'h13, "flags");
    irq_ack(1'b0, 1'b0, "xa ack");
    PM.set_xa(1'b1);
    PM.pulse(2);
    rc(8'h08, 8'h02, "ungated");
    wr(8'h04, 8'h00);
  endtask
  task t_split;
    wr(8'h00, 8'h03);
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'hfe);
    wr(8'h10, 8'h00);
    a_seen = 1'b0;
    b_seen = 1'b0;
    wr(8'h04, 8'h40);
    repeat (20) @(posedge clk);
    wr(8'h04, 8'h00);
    check("split b ovf", 8'h01, {7'h00, b_seen});
    check("split a ovf", 8'h00, {7'h00, a_seen});
    rc(8'h08, 8'h00, "split low");
    rc(8'h10, 8'h00, "b stopped");
  endtask
  task t_timer_b;
    wr(8'h00, 8'hd0);
    wr(8'h14, 8'hff);
    wr(8'h10, 8'hfe);
    b_seen = 1'b0;
    wr(8'h04, 8'h40);
    pulse_b(2);
    rc(8'h10, 8'h00, "b low");
    rc(8'h14, 8'h00, "b high");
    check("b ovf", 8'h01, {7'h00, b_seen});
    xb_pin_b <= 1'b0;
    pulse_b(1);
    rc(8'h10, 8'h00, "b gated");
    irq_ack(1'b1, 1'b1, "xb level held");
    xb_pin_b <= 1'b1;
    pulse_b(1);
    rc(8'h10, 8'h01, "b ungated");
    irq_ack(1'b1, 1'b0, "xb ack");
    wr(8'h04, 8'h00);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (a_req) a_seen <= 1'b1;
    if (b_req) b_seen <= 1'b1;
    if (xa_req) x_seen <= 1'b1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish;
    end
  end
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ev_b_pin = 1'b1;
    xb_pin_b = 1'b1;
    xa_ack = 1'b0;
    xb_ack = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_rate;
    t_cnt13;
    t_reload;
    t_gate;
    t_split;
    t_timer_b;
    tally_and_finish;
  end
endmodule
